// ### bench/adcrng_front.sv
// Purpose: Conversion core stand-in that hands results to the register bank
// Assumes: One request pulse from the bench per result
// Notes: Data outside the valid cycle inverts every cycle, so the stale value returns every second cycle

`timescale 1ns/100ps

module adcrng_front
(
	input wire logic i_clk,
	input wire logic i_req,
	input wire logic [17:0] i_data,
	output logic [17:0] o_conv_data,
	output logic o_conv_valid
);
	// ----------------------------------------
	// One-cycle result strobe
	// ----------------------------------------
	always_ff @(posedge i_clk)
	begin
		o_conv_valid <= i_req;
		o_conv_data <= i_req ? i_data : ~o_conv_data;
	end
endmodule // adcrng_front

// ### bench/testbench.sv
// Purpose: Self-checking bench for the output, range and alarm register bank
// Assumes: AXI4-Lite master tasks and a conversion source model
// Notes: Expected values come from the field layout only

`timescale 1ns/100ps

module testbench
	import adcrng_pkg::*;
;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic por_b = 1'b0;
	logic [7:0] awa = 8'h0;
	logic awv = 1'b0;
	logic [31:0] wd = 32'h0;
	logic wv = 1'b0;
	logic bre = 1'b0;
	logic [7:0] ara = 8'h0;
	logic arv = 1'b0;
	logic rre = 1'b0;
	logic req = 1'b0;
	logic [17:0] dat = 18'h0;
	logic [3:0] alm = 4'h0;
	logic [3:0] ws = 4'hf;
	logic awr, wrd, bv, arr, rv, fv, refd, irq, cvv;
	logic [1:0] br, rr;
	logic [31:0] rdat, fd;
	logic [17:0] ow, cd;
	logic [5:0] fl;
	logic [3:0] rc;
	int num_errors = 0;
	int total_checks = 0;
	localparam logic [17:0] CDAT = 18'h2a5a3;
	logic [3:0] codes [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h9, 4'ha, 4'hb};

	always #2.5 clk = ~clk;

	adcrng_front front (.i_clk(clk), .i_req(req), .i_data(dat), .o_conv_data(cd),
		.o_conv_valid(cvv));

	adcrng_regs DUT (.i_clk(clk), .i_rst_b(rst_b), .i_por_b(por_b),
		.i_s_axi_awaddr(awa), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr),
		.i_s_axi_wdata(wd), .i_s_axi_wstrb(ws), .i_s_axi_wvalid(wv),
		.o_s_axi_wready(wrd), .o_s_axi_bresp(br), .o_s_axi_bvalid(bv),
		.i_s_axi_bready(bre), .i_s_axi_araddr(ara), .i_s_axi_arvalid(arv),
		.o_s_axi_arready(arr), .o_s_axi_rdata(rdat), .o_s_axi_rresp(rr),
		.o_s_axi_rvalid(rv), .i_s_axi_rready(rre), .i_conv_data(cd),
		.i_conv_valid(cvv), .i_alarm_active(alm), .o_out_word(ow), .o_frame_data(fd),
		.o_frame_len(fl), .o_frame_valid(fv), .o_range_code(rc),
		.o_internal_ref_disable(refd), .o_irq(irq));

	// ----------------------------------------
	// Compare and bus tasks
	// ----------------------------------------
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
			num_errors++;
		end
	endtask

	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ha, hw;
		logic hb = 1'b0;
		int n = 0;
		@(posedge clk);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bre <= 1'b1;
		while (!hb && n < 100)
		begin
			@(negedge clk);
			ha = awv && awr;
			hw = wv && wrd;
			hb = bv && bre;
			r = br;
			n++;
			@(posedge clk);
			if (ha) awv <= 1'b0;
			if (hw) wv <= 1'b0;
			if (hb) bre <= 1'b0;
		end
		if (!hb) chk("write answer", 32'h1, 32'h0);
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ha;
		logic hr = 1'b0;
		int n = 0;
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rre <= 1'b1;
		while (!hr && n < 100)
		begin
			@(negedge clk);
			ha = arv && arr;
			hr = rv && rre;
			d = rdat;
			r = rr;
			n++;
			@(posedge clk);
			if (ha) arv <= 1'b0;
			if (hr) rre <= 1'b0;
		end
		if (!hr) chk("read answer", 32'h1, 32'h0);
	endtask

	task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		logic [1:0] r;
		axw(a, d, r);
		chk("bresp", e, r);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string n);
		logic [31:0] d;
		logic [1:0] r;
		axr(a, d, r);
		chk(n, e, d);
		chk("rresp", ADCRNG_RESP_OKAY, r);
	endtask

	task automatic conv(input logic [17:0] d);
		@(posedge clk);
		req <= 1'b1;
		dat <= d;
		@(posedge clk);
		req <= 1'b0;
		@(posedge clk);
		@(negedge clk);
		chk("frame valid", 32'h1, fv);
	endtask

	function automatic logic [17:0] pw(input int p);
		case (p)
			4: return 18'h0;
			5: return 18'h3ffff;
			6: return 18'h15555;
			7: return 18'h0cccc;
			default: return CDAT;
		endcase
	endfunction

	task automatic close_out;
		$display("Checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ----------------------------------------
	// Watchdog and test sequence
	// ----------------------------------------
	initial
	begin
		repeat (20000) @(posedge clk);
		num_errors++;
		close_out();
	end

	initial
	begin
		logic [31:0] d;
		logic [1:0] r;
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		por_b <= 1'b1;
		rdc(8'h10, 32'h0, "dout reset");
		rdc(8'h14, 32'h0, "range reset");
		rdc(8'h20, 32'h0, "alarm reset");
		wrc(8'h10, 32'hffffffff, ADCRNG_RESP_OKAY);
		rdc(8'h10, 32'h10f, "dout rsvd");
		wrc(8'h14, 32'hffffff4b, ADCRNG_RESP_OKAY);
		rdc(8'h14, 32'h4b, "range rsvd");
		rdc(8'h17, 32'h4b, "range lane");
		chk("refdis", 32'h1, refd);
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		rdc(8'h14, 32'hb, "range app rst");
		chk("refdis app rst", 32'h0, refd);
		por_b <= 1'b0;
		repeat (2) @(posedge clk);
		por_b <= 1'b1;
		rdc(8'h14, 32'h0, "range por");
		for (int i = 0; i < 9; i++)
		begin
			wrc(8'h14, {28'h0, codes[i]}, ADCRNG_RESP_OKAY);
			chk("range code", codes[i], rc);
		end
		ws <= 4'he;
		wrc(8'h14, 32'hffffff40, ADCRNG_RESP_OKAY);
		rdc(8'h14, 32'hb, "range lane off");
		ws <= 4'h1;
		wrc(8'h14, 32'hffffff4b, ADCRNG_RESP_OKAY);
		rdc(8'h14, 32'h4b, "range lane on");
		ws <= 4'hf;
		for (int p = 0; p < 8; p++)
		begin
			wrc(8'h10, p, ADCRNG_RESP_OKAY);
			conv(CDAT);
			chk("out word", pw(p), ow);
			chk("frame len", 32'h12, fl);
		end
		wrc(8'h10, 32'h100, ADCRNG_RESP_OKAY);
		conv(CDAT);
		chk("len range", 32'h16, fl);
		chk("frame range only", {10'h0, CDAT, 4'hb}, fd);
		wrc(8'h10, 32'h108, ADCRNG_RESP_OKAY);
		conv(CDAT);
		chk("len range par", 32'h18, fl);
		chk("frame range", {8'h0, CDAT, 4'hb, ^CDAT, ^{CDAT, 4'hb}}, fd);
		wrc(8'h10, 32'h8, ADCRNG_RESP_OKAY);
		conv(CDAT);
		chk("len par", 32'h14, fl);
		chk("frame par", {12'h0, CDAT, ^CDAT, ^CDAT}, fd);
		wrc(8'h34, 32'h0, ADCRNG_RESP_OKAY);
		alm <= 4'ha;
		repeat (3) @(posedge clk);
		rdc(8'h20, 32'h88a1, "alarm live");
		chk("irq masked", 32'h0, irq);
		rdc(8'h30, 32'ha, "irq status");
		wrc(8'h34, 32'hf, ADCRNG_RESP_OKAY);
		repeat (2) @(negedge clk);
		chk("irq raised", 32'h1, irq);
		@(posedge clk);
		alm <= 4'h0;
		rdc(8'h20, 32'ha1, "alarm tripped");
		rdc(8'h20, 32'h0, "alarm cleared");
		wrc(8'h20, 32'hffffffff, ADCRNG_RESP_OKAY);
		rdc(8'h20, 32'h0, "alarm ro");
		wrc(8'h30, 32'h2, ADCRNG_RESP_OKAY);
		rdc(8'h30, 32'h8, "irq w1c");
		chk("irq held", 32'h1, irq);
		wrc(8'h30, 32'h8, ADCRNG_RESP_OKAY);
		repeat (2) @(negedge clk);
		chk("irq clear", 32'h0, irq);
		wrc(8'h40, 32'hffffffff, ADCRNG_RESP_SLVERR);
		axr(8'h40, d, r);
		chk("unmapped data", 32'h0, d);
		chk("unmapped resp", ADCRNG_RESP_SLVERR, r);
		close_out();
	end
endmodule // testbench

// ### verilog/adcrng_pkg.sv
// Purpose: Constants and types for the converter output, range and alarm register bank
// Assumes: 32-bit AXI4-Lite register access, one aligned word per register
// Notes: Offsets are byte addresses

package adcrng_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] ADCRNG_OFS_DOUT = 8'h10;
	localparam logic [7:0] ADCRNG_OFS_RANGE = 8'h14;
	localparam logic [7:0] ADCRNG_OFS_ALARM = 8'h20;
	localparam logic [7:0] ADCRNG_OFS_IRQ_STAT = 8'h30;
	localparam logic [7:0] ADCRNG_OFS_IRQ_MASK = 8'h34;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int ADCRNG_POS_PAT = 0;
	localparam int ADCRNG_POS_PAR = 3;
	localparam int ADCRNG_POS_RINCL = 8;
	localparam int ADCRNG_POS_RCODE = 0;
	localparam int ADCRNG_POS_REFDIS = 6;
	localparam int ADCRNG_POS_ACTIVE_HI = 14;
	localparam int ADCRNG_POS_ACTIVE_LO = 10;
	localparam int ADCRNG_POS_TRIP = 4;
	localparam int ADCRNG_POS_SUMMARY = 0;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [2:0] ADCRNG_RST_PAT = 3'h0;
	localparam logic ADCRNG_RST_PAR = 1'h0;
	localparam logic ADCRNG_RST_RINCL = 1'h0;
	localparam logic ADCRNG_RST_REFDIS = 1'h0;
	localparam logic [3:0] ADCRNG_RST_RCODE = 4'h0;
	localparam logic [3:0] ADCRNG_RST_FLAGS = 4'h0;

	// ----------------------------------------
	// Data widths, patterns, frame sizes
	// ----------------------------------------
	localparam int ADCRNG_CONV_W = 18;
	localparam logic [5:0] ADCRNG_LEN_BASE = 6'h12;
	localparam logic [5:0] ADCRNG_LEN_RANGE = 6'h04;
	localparam logic [5:0] ADCRNG_LEN_PAR = 6'h02;
	localparam logic [2:0] ADCRNG_PAT_ZERO = 3'h4;
	localparam logic [2:0] ADCRNG_PAT_ONES = 3'h5;
	localparam logic [2:0] ADCRNG_PAT_ALT1 = 3'h6;
	localparam logic [2:0] ADCRNG_PAT_ALT2 = 3'h7;
	localparam logic [17:0] ADCRNG_WORD_ALT1 = 18'h15555;
	localparam logic [17:0] ADCRNG_WORD_ALT2 = 18'h0cccc;
	localparam logic [1:0] ADCRNG_RESP_OKAY = 2'h0;
	localparam logic [1:0] ADCRNG_RESP_SLVERR = 2'h2;

	// ----------------------------------------
	// Bus channel states
	// ----------------------------------------
	typedef enum logic [1:0] {ADCRNG_WS_COLLECT = 2'b01, ADCRNG_WS_RESP = 2'b10} adcrng_wst_t;
	typedef enum logic [1:0] {ADCRNG_RS_IDLE = 2'b01, ADCRNG_RS_DATA = 2'b10} adcrng_rst_t;

endpackage

// ### verilog/adcrng_regs.sv
// Purpose: Output pattern, range/reference select and alarm flag registers over AXI4-Lite
// Assumes: Alarm comparators and conversion core run on i_clk
// Notes: i_por_b clears everything, i_rst_b keeps the input range code
//
// Contract
// - Pattern select with top bit zero sends the real conversion result.
// - Pattern 100b sends all zeros and pattern 101b sends all ones.
// - Pattern 110b sends single alternating bits and 111b sends alternating pairs.
// - Parity append makes the output frame exactly two bits longer.
// - Range register bit 6 disables the internal reference when set and resets to 0.
// - Range codes 0000b to 0100b pick the bipolar spans 3, 2.5, 1.5, 1.25, 0.625 x Vref.
// - Range codes 1000b to 1011b pick the unipolar spans 3, 2.5, 1.5, 1.25 x Vref.
// - The range code clears only on power-on reset and survives application reset.
// - Reserved fields are read-only and read as zero.
// - Each register takes four byte addresses low byte first, range at 14h to 17h.
// - The alarm register is read-only at 20h to 23h with all flags resetting to zero; here the live flags are not reset and follow i_alarm_active.
// - Live alarm flags sit at bits 15, 14, 11 and 10.
// - Tripped flags sit at bits 7 to 4 and a summary flag at bit 0.
// - The summary flag is the OR of all tripped flags.
// - Range-in-frame enable inserts the 4-bit range code into the output frame.
//
// Local design decision: register access over AXI4-Lite.

`timescale 1ns/100ps

module adcrng_regs
	import adcrng_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_por_b,
	input wire logic [7:0] i_s_axi_awaddr,
	input wire logic i_s_axi_awvalid,
	output logic o_s_axi_awready,
	input wire logic [31:0] i_s_axi_wdata,
	input wire logic [3:0] i_s_axi_wstrb,
	input wire logic i_s_axi_wvalid,
	output logic o_s_axi_wready,
	output logic [1:0] o_s_axi_bresp,
	output logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	input wire logic [7:0] i_s_axi_araddr,
	input wire logic i_s_axi_arvalid,
	output logic o_s_axi_arready,
	output logic [31:0] o_s_axi_rdata,
	output logic [1:0] o_s_axi_rresp,
	output logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready,
	input wire logic [17:0] i_conv_data,
	input wire logic i_conv_valid,
	input wire logic [3:0] i_alarm_active,
	output logic [17:0] o_out_word,
	output logic [31:0] o_frame_data,
	output logic [5:0] o_frame_len,
	output logic o_frame_valid,
	output logic [3:0] o_range_code,
	output logic o_internal_ref_disable,
	output logic o_irq
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		adcrng_wst_t wst;
		logic aw_got;
		logic w_got;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic [1:0] bresp;
		adcrng_rst_t rst;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic rd_alarm;
		logic [2:0] pat_sel;
		logic parity_append_enable;
		logic range_in_frame_enable;
		logic internal_ref_disable;
		logic [3:0] range_code;
		logic [3:0] trip;
		logic [3:0] irq_stat;
		logic [3:0] irq_mask;
		logic [17:0] out_word;
		logic [31:0] frame;
		logic [5:0] frame_len;
		logic frame_valid;
	} adcrng_state_t;

	adcrng_state_t s_r, s_nxt, s_rst;
	logic aw_now, w_now, ar_now, wr_do, rd_hit;
	logic [7:0] wr_addr;
	logic [31:0] wr_data, rd_val, fr, dout_new, range_new;
	logic [3:0] wr_strb, w1c;
	logic [17:0] word;
	logic [5:0] fl;

	function automatic logic [31:0] adcrng_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++)
		begin
			if (strb[b])
			begin
				res[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		s_rst = '0;
		s_rst.wst = ADCRNG_WS_COLLECT;
		s_rst.rst = ADCRNG_RS_IDLE;
		s_rst.pat_sel = ADCRNG_RST_PAT;
		s_rst.parity_append_enable = ADCRNG_RST_PAR;
		s_rst.range_in_frame_enable = ADCRNG_RST_RINCL;
		s_rst.internal_ref_disable = ADCRNG_RST_REFDIS;
		s_rst.range_code = ADCRNG_RST_RCODE;
		s_rst.trip = ADCRNG_RST_FLAGS;
		s_nxt = s_r;
		s_nxt.frame_valid = 1'b0;
		o_s_axi_awready = (s_r.wst == ADCRNG_WS_COLLECT) && !s_r.aw_got;
		o_s_axi_wready = (s_r.wst == ADCRNG_WS_COLLECT) && !s_r.w_got;
		o_s_axi_arready = (s_r.rst == ADCRNG_RS_IDLE);
		aw_now = i_s_axi_awvalid && o_s_axi_awready;
		w_now = i_s_axi_wvalid && o_s_axi_wready;
		ar_now = i_s_axi_arvalid && o_s_axi_arready;
		wr_addr = s_r.aw_got ? s_r.awaddr : i_s_axi_awaddr;
		wr_data = s_r.w_got ? s_r.wdata : i_s_axi_wdata;
		wr_strb = s_r.w_got ? s_r.wstrb : i_s_axi_wstrb;
		wr_do = (s_r.aw_got || aw_now) && (s_r.w_got || w_now);
		dout_new = adcrng_merge({23'h0, s_r.range_in_frame_enable, 4'h0, s_r.parity_append_enable,
			s_r.pat_sel}, wr_data, wr_strb);
		range_new = adcrng_merge({25'h0, s_r.internal_ref_disable, 2'h0, s_r.range_code},
			wr_data, wr_strb);
		w1c = 4'h0;
		rd_hit = 1'b1;
		rd_val = 32'h0;
		word = i_conv_data;
		fr = 32'h0;
		fl = ADCRNG_LEN_BASE;

		// Address and data may arrive in either order
		if (aw_now)
		begin
			s_nxt.aw_got = 1'b1;
			s_nxt.awaddr = i_s_axi_awaddr;
		end
		if (w_now)
		begin
			s_nxt.w_got = 1'b1;
			s_nxt.wdata = i_s_axi_wdata;
			s_nxt.wstrb = i_s_axi_wstrb;
		end
		if (wr_do)
		begin
			s_nxt.aw_got = 1'b0;
			s_nxt.w_got = 1'b0;
			s_nxt.wst = ADCRNG_WS_RESP;
			s_nxt.bresp = ADCRNG_RESP_OKAY;
			case (wr_addr[7:2])
				ADCRNG_OFS_DOUT[7:2]:
				begin
					s_nxt.pat_sel = dout_new[ADCRNG_POS_PAT +: 3];
					s_nxt.parity_append_enable = dout_new[ADCRNG_POS_PAR];
					s_nxt.range_in_frame_enable = dout_new[ADCRNG_POS_RINCL];
				end
				ADCRNG_OFS_RANGE[7:2]:
				begin
					s_nxt.internal_ref_disable = range_new[ADCRNG_POS_REFDIS];
					s_nxt.range_code = range_new[ADCRNG_POS_RCODE +: 4];
				end
				ADCRNG_OFS_ALARM[7:2]: s_nxt.bresp = ADCRNG_RESP_OKAY;
				ADCRNG_OFS_IRQ_STAT[7:2]: w1c = wr_strb[0] ? wr_data[3:0] : 4'h0;
				ADCRNG_OFS_IRQ_MASK[7:2]:
				begin
					s_nxt.irq_mask = wr_strb[0] ? wr_data[3:0] : s_r.irq_mask;
				end
				default:
				begin
					s_nxt.bresp = ADCRNG_RESP_SLVERR;
				end
			endcase
		end
		if (s_r.wst == ADCRNG_WS_RESP && i_s_axi_bready)
		begin
			s_nxt.wst = ADCRNG_WS_COLLECT;
		end

		// Read mux
		// reserved bits read zero
		case (i_s_axi_araddr[7:2])
			ADCRNG_OFS_DOUT[7:2]:
			begin
				rd_val[ADCRNG_POS_PAT +: 3] = s_r.pat_sel;
				rd_val[ADCRNG_POS_PAR] = s_r.parity_append_enable;
				rd_val[ADCRNG_POS_RINCL] = s_r.range_in_frame_enable;
			end
			ADCRNG_OFS_RANGE[7:2]:
			begin
				rd_val[ADCRNG_POS_REFDIS] = s_r.internal_ref_disable;
				rd_val[ADCRNG_POS_RCODE +: 4] = s_r.range_code;
			end
			ADCRNG_OFS_ALARM[7:2]:
			begin
				rd_val[ADCRNG_POS_ACTIVE_HI +: 2] = i_alarm_active[3:2];
				rd_val[ADCRNG_POS_ACTIVE_LO +: 2] = i_alarm_active[1:0];
				rd_val[ADCRNG_POS_TRIP +: 4] = s_r.trip;
				rd_val[ADCRNG_POS_SUMMARY] = |s_r.trip;
			end
			ADCRNG_OFS_IRQ_STAT[7:2]: rd_val[3:0] = s_r.irq_stat;
			ADCRNG_OFS_IRQ_MASK[7:2]: rd_val[3:0] = s_r.irq_mask;
			default: rd_hit = 1'b0;
		endcase
		if (ar_now)
		begin
			s_nxt.rst = ADCRNG_RS_DATA;
			s_nxt.rdata = rd_val;
			s_nxt.rresp = rd_hit ? ADCRNG_RESP_OKAY : ADCRNG_RESP_SLVERR;
			s_nxt.rd_alarm = (i_s_axi_araddr[7:2] == ADCRNG_OFS_ALARM[7:2]);
		end
		if (s_r.rst == ADCRNG_RS_DATA && i_s_axi_rready)
		begin
			s_nxt.rst = ADCRNG_RS_IDLE;
		end

		// tripped flags clear on alarm read, a new trip wins
		s_nxt.trip = (ar_now && i_s_axi_araddr[7:2] == ADCRNG_OFS_ALARM[7:2]) ?
			i_alarm_active : (s_r.trip | i_alarm_active);
		s_nxt.irq_stat = (s_r.irq_stat & ~w1c) | (i_alarm_active & ~s_r.trip);

		// Output frame build
		case (s_r.pat_sel)
			ADCRNG_PAT_ZERO: word = '0;
			ADCRNG_PAT_ONES: word = '1;
			ADCRNG_PAT_ALT1: word = ADCRNG_WORD_ALT1;
			ADCRNG_PAT_ALT2: word = ADCRNG_WORD_ALT2;
			default: word = i_conv_data;
		endcase
		fr = {14'h0, word};
		if (s_r.range_in_frame_enable)
		begin
			fr = {fr[27:0], s_r.range_code};
			fl = 6'(fl + ADCRNG_LEN_RANGE);
		end
		if (s_r.parity_append_enable)
		begin
			fr = {fr[29:0], ^word, ^fr};
			fl = 6'(fl + ADCRNG_LEN_PAR);
		end
		if (i_conv_valid)
		begin
			s_nxt.out_word = word;
			s_nxt.frame = fr;
			s_nxt.frame_len = fl;
			s_nxt.frame_valid = 1'b1;
		end

		// application reset keeps the range code
		if (!i_por_b)
		begin
			s_nxt = s_rst;
		end
		else if (!i_rst_b)
		begin
			s_nxt = s_rst;
			s_nxt.range_code = s_r.range_code;
		end
	end

	always_ff @(posedge i_clk)
	begin
		s_r <= s_nxt;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign o_s_axi_bvalid = (s_r.wst == ADCRNG_WS_RESP);
	assign o_s_axi_bresp = s_r.bresp;
	assign o_s_axi_rvalid = (s_r.rst == ADCRNG_RS_DATA);
	assign o_s_axi_rdata = s_r.rdata;
	assign o_s_axi_rresp = s_r.rresp;
	assign o_out_word = s_r.out_word;
	assign o_frame_data = s_r.frame;
	assign o_frame_len = s_r.frame_len;
	assign o_frame_valid = s_r.frame_valid;
	// range code steers the bipolar spans
	// range code steers the unipolar spans
	assign o_range_code = s_r.range_code;
	assign o_internal_ref_disable = s_r.internal_ref_disable;
	assign o_irq = |(s_r.irq_stat & s_r.irq_mask);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking adcrng_cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_b || !i_por_b);

	pass_conv_a: assert property (i_conv_valid && !s_r.pat_sel[2] |=>
		o_frame_valid && o_out_word == $past(i_conv_data))
		else $error("conversion data not passed");
	fixed_words_a: assert property (i_conv_valid && s_r.pat_sel[2:1] == 2'b10 |=>
		o_out_word == {18{$past(s_r.pat_sel[0])}})
		else $error("fixed pattern wrong");
	alt_words_a: assert property (i_conv_valid && s_r.pat_sel == ADCRNG_PAT_ALT2 |=>
		o_out_word == ADCRNG_WORD_ALT2 && o_frame_valid)
		else $error("pair pattern wrong");
	parity_len_a: assert property (i_conv_valid && s_r.parity_append_enable &&
		!s_r.range_in_frame_enable |=> o_frame_len == 6'(ADCRNG_LEN_BASE + ADCRNG_LEN_PAR))
		else $error("parity length wrong");
	range_len_a: assert property (i_conv_valid && s_r.range_in_frame_enable &&
		!s_r.parity_append_enable |=> o_frame_len == 6'(ADCRNG_LEN_BASE + ADCRNG_LEN_RANGE) &&
		o_frame_data[3:0] == $past(s_r.range_code))
		else $error("range code not in frame");
	refdis_write_a: assert property (wr_do && wr_addr[7:2] == ADCRNG_OFS_RANGE[7:2] &&
		wr_strb[0] |=> o_internal_ref_disable == $past(wr_data[ADCRNG_POS_REFDIS]) &&
		o_s_axi_bvalid)
		else $error("reference disable not written");
	range_keep_a: assert property (@(posedge i_clk) disable iff (!i_por_b)
		!i_rst_b |=> $stable(o_range_code))
		else $error("range code lost on app reset");
	resv_zero_a: assert property (o_s_axi_rvalid |-> o_s_axi_rdata[31:16] == 16'h0)
		else $error("reserved bits nonzero");
	summary_or_a: assert property (o_s_axi_rvalid && s_r.rd_alarm |->
		o_s_axi_rdata[0] == |o_s_axi_rdata[7:4] && o_s_axi_rdata[3:1] == 3'h0)
		else $error("summary flag wrong");
	alarm_ro_a: assert property (wr_do && wr_addr[7:2] == ADCRNG_OFS_ALARM[7:2] &&
		!ar_now |=> s_r.trip == ($past(s_r.trip) | $past(i_alarm_active)))
		else $error("alarm write had effect");

	write_seen_c: cover property (wr_do ##[1:4] o_s_axi_bvalid && i_s_axi_bready);
	alarm_read_c: cover property (ar_now && i_s_axi_araddr == ADCRNG_OFS_ALARM ##1 o_s_axi_rvalid);
	pair_frame_c: cover property (i_conv_valid && s_r.pat_sel == ADCRNG_PAT_ALT2 &&
		s_r.parity_append_enable);
	irq_rise_c: cover property (!o_irq ##1 o_irq);

endmodule // adcrng_regs
